// *** design/cfg_bank_pkg.sv ***
// constants for the status-pin and mute-level configuration bank
`default_nettype none
package cfg_bank_pkg;
   // register indexes; byte address is four times the index
   localparam logic [7:0] IDX_STAT = 8'h13;
   localparam logic [7:0] IDX_MUTE = 8'h14;
   localparam logic [9:0] ADDR_STAT = {IDX_STAT, 2'b00};
   localparam logic [9:0] ADDR_MUTE = {IDX_MUTE, 2'b00};
   // status_pin_driver_control fields
   localparam int BIT_OD0    = 0;
   localparam int BIT_OD1    = 1;
   localparam int BIT_LIM0   = 4;
   localparam int BIT_LIM1   = 5;
   localparam logic [7:0] STAT_RW_MASK = 8'h3F;   // bits 7:6 read zero
   localparam logic [7:0] STAT_RESET   = 8'h00;
   // mute_level_channels_0_to_3: two bits per channel, channel n at 2n+1:2n
   localparam int CODE_W = 2;
   localparam int NCHAN  = 4;
   localparam logic [7:0] MUTE_RESET = 8'h55;    // every code resets to 1
   localparam logic [1:0] CODE_BYPASS = 2'h0;
   localparam logic [1:0] CODE_VCM    = 2'h1;
   localparam logic [1:0] CODE_HIGH   = 2'h2;
   localparam logic [1:0] CODE_LOW    = 2'h3;
   localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
endpackage : cfg_bank_pkg
`default_nettype wire

// *** design/status_pin_and_mute_level_config.sv ***
// register bank for status pin drivers and channel mute levels, AHB-Lite slave
// Behaviour
// R1: status_pin_driver_control bit 1 makes second_status_pin open-drain, else push-pull.
// R2: status_pin_driver_control bit 0 makes first_status_pin open-drain, else push-pull.
// R3: bit 5 asserts the second status driver's spike current limit.
// R4: bit 4 asserts the first status driver's spike current limit.
// R5: mute register holds four 2-bit codes, ch3 at 7:6, ch2 at 5:4, reset 1.
// R6: code 1 muted: diff powers down to common mode; cmos forces negative low.
// R7: code 2 diff high, cmos positive low; code 3 diff low, cmos both low.
// R8: code picks the muted state only; mute itself comes from an outside input.
//
// The AHB-Lite slave port is this design's own decision.
`default_nettype none
module status_pin_and_mute_level_config #(
   parameter int NCH = 4
) (
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic             ce,
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic      [31:0]      hrdata,
   output logic                  hreadyout,
   output logic                  hresp,
   input  wire logic             first_status_level,
   input  wire logic             second_status_level,
   output logic                  first_status_pin_o,
   output logic                  first_status_pin_oe,
   output logic                  second_status_pin_o,
   output logic                  second_status_pin_oe,
   output logic                  status_pin0_spike_limit,
   output logic                  status_pin1_spike_limit,
   input  wire logic [NCH-1:0]   chan_mute,
   input  wire logic [NCH-1:0]   chan_cmos,
   output logic      [NCH-1:0]   chan_pwrdn_vcm,
   output logic      [NCH-1:0]   chan_force_high,
   output logic      [NCH-1:0]   chan_force_low,
   output logic      [NCH-1:0]   chan_p_low,
   output logic      [NCH-1:0]   chan_n_low
);

   typedef struct packed {
      logic           wr_pend;
      logic           rd_pend;
      logic           hit_stat;
      logic           hit_mute;
      logic [7:0]     stat;
      logic [7:0]     mute;
      logic           mute_written;
      logic           p0_o;
      logic           p0_oe;
      logic           p1_o;
      logic           p1_oe;
      logic [NCH-1:0] pwrdn;
      logic [NCH-1:0] fhigh;
      logic [NCH-1:0] flow;
      logic [NCH-1:0] plow;
      logic [NCH-1:0] nlow;
   } state_type;

   state_type st_q;
   state_type st_d;
   logic      take;
   logic [1:0] code;

   // a frozen block stretches the data phase rather than drop a transfer
   assign hreadyout = ce;
   assign hresp     = 1'b0;
   assign take      = hsel && htrans[1] && hready && ce;

   // read data from the latched decode; unmapped reads return zero
   always_comb
   begin
      hrdata = 32'h0000_0000;
      if (st_q.rd_pend && st_q.hit_stat)
         hrdata[7:0] = st_q.stat & cfg_bank_pkg::STAT_RW_MASK;
      else if (st_q.rd_pend && st_q.hit_mute)
         hrdata[7:0] = st_q.mute;
   end

   assign status_pin0_spike_limit = st_q.stat[cfg_bank_pkg::BIT_LIM0]; // [R4]
   assign status_pin1_spike_limit = st_q.stat[cfg_bank_pkg::BIT_LIM1]; // [R3]
   assign first_status_pin_o      = st_q.p0_o;
   assign first_status_pin_oe     = st_q.p0_oe;
   assign second_status_pin_o     = st_q.p1_o;
   assign second_status_pin_oe    = st_q.p1_oe;
   assign chan_pwrdn_vcm          = st_q.pwrdn;
   assign chan_force_high         = st_q.fhigh;
   assign chan_force_low          = st_q.flow;
   assign chan_p_low              = st_q.plow;
   assign chan_n_low              = st_q.nlow;

   // next state: bus phases, register writes, pin and channel drive
   always_comb
   begin
      code = cfg_bank_pkg::CODE_BYPASS;
      st_d = st_q;
      // data phase of an accepted write; hsize is not checked, word only
      if (st_q.wr_pend && st_q.hit_stat)
         st_d.stat = hwdata[7:0] & cfg_bank_pkg::STAT_RW_MASK;
      if (st_q.wr_pend && st_q.hit_mute)
      begin
         st_d.mute         = hwdata[7:0]; // [R5]
         st_d.mute_written = 1'b1;
      end
      // address phase
      st_d.wr_pend  = take && hwrite;
      st_d.rd_pend  = take && !hwrite;
      st_d.hit_stat = take && (haddr[9:0] == cfg_bank_pkg::ADDR_STAT) && (haddr[31:10] == '0);
      st_d.hit_mute = take && (haddr[9:0] == cfg_bank_pkg::ADDR_MUTE) && (haddr[31:10] == '0);
      // open-drain only pulls low; push-pull always drives
      st_d.p0_o  = st_q.stat[cfg_bank_pkg::BIT_OD0] ? 1'b0 : first_status_level; // [R2]
      st_d.p0_oe = st_q.stat[cfg_bank_pkg::BIT_OD0] ? !first_status_level : 1'b1; // [R2]
      st_d.p1_o  = st_q.stat[cfg_bank_pkg::BIT_OD1] ? 1'b0 : second_status_level; // [R1]
      st_d.p1_oe = st_q.stat[cfg_bank_pkg::BIT_OD1] ? !second_status_level : 1'b1; // [R1]
      // channel drive; an unmuted channel is left alone whatever its code
      for (int k = 0; k < NCH; k++)
      begin
         code = st_q.mute[k*cfg_bank_pkg::CODE_W +: cfg_bank_pkg::CODE_W];
         st_d.pwrdn[k] = chan_mute[k] && !chan_cmos[k]
                         && (code == cfg_bank_pkg::CODE_VCM); // [R6] [R8]
         st_d.fhigh[k] = chan_mute[k] && !chan_cmos[k]
                         && (code == cfg_bank_pkg::CODE_HIGH); // [R7]
         st_d.flow[k]  = chan_mute[k] && !chan_cmos[k]
                         && (code == cfg_bank_pkg::CODE_LOW); // [R7]
         st_d.plow[k]  = chan_mute[k] && chan_cmos[k]
                         && (code == cfg_bank_pkg::CODE_HIGH
                             || code == cfg_bank_pkg::CODE_LOW); // [R7]
         st_d.nlow[k]  = chan_mute[k] && chan_cmos[k]
                         && (code == cfg_bank_pkg::CODE_VCM
                             || code == cfg_bank_pkg::CODE_LOW); // [R6] [R7]
      end
   end

   // one register for all state; clock enable freezes everything
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_q      <= '0;
         st_q.stat <= cfg_bank_pkg::STAT_RESET;
         st_q.mute <= cfg_bank_pkg::MUTE_RESET; // [R5]
         st_q.p0_oe <= 1'b1;
         st_q.p1_oe <= 1'b1;
      end
      else if (ce)
         st_q <= st_d;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   // codes of the two channels that the channel checks watch
   logic [cfg_bank_pkg::CODE_W-1:0] ch3_code;
   logic [cfg_bank_pkg::CODE_W-1:0] ch2_code;
   assign ch3_code = st_q.mute[3*cfg_bank_pkg::CODE_W +: cfg_bank_pkg::CODE_W];
   assign ch2_code = st_q.mute[2*cfg_bank_pkg::CODE_W +: cfg_bank_pkg::CODE_W];

   // status pins follow the register and the wanted level one edge later
   a_od0_drive: assert property (ce |=> first_status_pin_oe == // [R2]
      ($past(st_q.stat[cfg_bank_pkg::BIT_OD0]) ? !$past(first_status_level) : 1'b1))
      else $error("first status pin enable wrong");
   a_od0_level: assert property (ce |=> first_status_pin_o == // [R2]
      ($past(st_q.stat[cfg_bank_pkg::BIT_OD0]) ? 1'b0 : $past(first_status_level)))
      else $error("first status pin level wrong");
   a_od1_drive: assert property (ce |=> second_status_pin_o == // [R1]
      ($past(st_q.stat[cfg_bank_pkg::BIT_OD1]) ? 1'b0 : $past(second_status_level)))
      else $error("second status pin level wrong");
   a_od1_enable: assert property (ce |=> second_status_pin_oe == // [R1]
      ($past(st_q.stat[cfg_bank_pkg::BIT_OD1]) ? !$past(second_status_level) : 1'b1))
      else $error("second status pin enable wrong");

   // a low enable holds the drive, so a pin cannot glitch while the bank is frozen
   a_frozen_pins: assert property (!ce |=> $stable(first_status_pin_oe) // [R2] [R1]
      && $stable(second_status_pin_oe) && $stable(status_pin0_spike_limit)
      && $stable(chan_force_low))
      else $error("outputs moved while frozen");

   // a written control word reaches the spike limits at the next edge
   a_lim0_write: assert property (ce && st_q.wr_pend && st_q.hit_stat // [R4]
      |=> status_pin0_spike_limit == $past(hwdata[cfg_bank_pkg::BIT_LIM0]))
      else $error("spike limit 0 not written");
   a_lim1_write: assert property (ce && st_q.wr_pend && st_q.hit_stat // [R3]
      |=> status_pin1_spike_limit == $past(hwdata[cfg_bank_pkg::BIT_LIM1]))
      else $error("spike limit 1 not written");

   // mute codes keep their reset value until written, then take the data phase word
   a_mute_reset: assert property (!st_q.mute_written // [R5]
      |-> st_q.mute == cfg_bank_pkg::MUTE_RESET)
      else $error("mute codes lost reset value");
   a_mute_write: assert property (ce && st_q.wr_pend && st_q.hit_mute // [R5]
      |=> st_q.mute == $past(hwdata[7:0]))
      else $error("mute codes not written");

   // channel 3 is watched in differential mode, channel 2 in cmos mode
   a_bypass_idle: assert property (ce && chan_mute[3] // [R5]
      && ch3_code == cfg_bank_pkg::CODE_BYPASS |=> !chan_pwrdn_vcm[3]
      && !chan_force_high[3] && !chan_force_low[3] && !chan_p_low[3] && !chan_n_low[3])
      else $error("bypassed channel forced");
   a_diff_vcm: assert property (ce && chan_mute[3] && !chan_cmos[3] // [R6]
      && ch3_code == cfg_bank_pkg::CODE_VCM |=> chan_pwrdn_vcm[3] && !chan_force_high[3])
      else $error("channel 3 powerdown missing");
   a_diff_high: assert property (ce && chan_mute[3] && !chan_cmos[3] // [R7]
      && ch3_code == cfg_bank_pkg::CODE_HIGH |=> chan_force_high[3] && !chan_force_low[3])
      else $error("channel 3 not driven high");
   a_diff_low: assert property (ce && chan_mute[3] && !chan_cmos[3] // [R7]
      && ch3_code == cfg_bank_pkg::CODE_LOW |=> chan_force_low[3] && !chan_pwrdn_vcm[3])
      else $error("channel 3 not driven low");
   a_cmos_vcm: assert property (ce && chan_mute[2] && chan_cmos[2] // [R6]
      && ch2_code == cfg_bank_pkg::CODE_VCM |=> chan_n_low[2] && !chan_p_low[2])
      else $error("channel 2 negative output not low");
   a_cmos_high: assert property (ce && chan_mute[2] && chan_cmos[2] // [R7]
      && ch2_code == cfg_bank_pkg::CODE_HIGH |=> chan_p_low[2] && !chan_n_low[2])
      else $error("channel 2 positive output not low");
   a_cmos_low: assert property (ce && chan_mute[2] && chan_cmos[2] // [R7]
      && ch2_code == cfg_bank_pkg::CODE_LOW |=> chan_p_low[2] && chan_n_low[2])
      else $error("channel 2 cmos not both low");
   a_cmos_no_diff: assert property (ce && chan_cmos[2] // [R6] [R7]
      |=> !chan_pwrdn_vcm[2] && !chan_force_high[2] && !chan_force_low[2])
      else $error("cmos channel given differential drive");
   a_unmuted_idle: assert property (ce && !chan_mute[2] // [R8]
      |=> !chan_p_low[2] && !chan_n_low[2] && !chan_force_low[2])
      else $error("unmuted channel forced");

endmodule // status_pin_and_mute_level_config
`default_nettype wire

// *** verif/testbench.sv ***
// self-checking bench for the status pin and mute level register bank
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] A_STAT = {22'h0, cfg_bank_pkg::ADDR_STAT};
   localparam logic [31:0] A_MUTE = {22'h0, cfg_bank_pkg::ADDR_MUTE};
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        s0_lvl = 1'b0;
   logic        s1_lvl = 1'b0;
   logic [3:0]  chan_mute = 4'h0;
   logic [3:0]  chan_cmos = 4'h5;    // channels 0 and 2 cmos, 1 and 3 differential
   logic        ce = 1'b1;
   logic [31:0] hrdata;
   logic        hreadyout, hresp, p0_o, p0_oe, p1_o, p1_oe, lim0, lim1;
   logic [3:0]  vcm, fhi, flo, plo, nlo;
   int          err_count = 0;
   int          checks = 0;
   int          cycles = 0;
   always #4 clk = ~clk;
   // single slave, so its hreadyout is the bus hready
   status_pin_and_mute_level_config #(.NCH(4)) uut (
      .clk(clk), .arst_n(arst_n), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .first_status_level(s0_lvl),
      .second_status_level(s1_lvl),
      .first_status_pin_o(p0_o), .first_status_pin_oe(p0_oe), .second_status_pin_o(p1_o),
      .second_status_pin_oe(p1_oe), .status_pin0_spike_limit(lim0),
      .status_pin1_spike_limit(lim1), .chan_mute(chan_mute), .chan_cmos(chan_cmos),
      .chan_pwrdn_vcm(vcm), .chan_force_high(fhi), .chan_force_low(flo), .chan_p_low(plo),
      .chan_n_low(nlo));
   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // entered just after a rising edge; each phase is held until hready is seen high
   task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rdck(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(a, 1'b0, 8'h00, r);
      check(r, exp);
   endtask
   task automatic reset_test();
      rdck(A_STAT, 32'h0);
      rdck(A_MUTE, 32'h55);
      check({p0_o, p0_oe, p1_o, p1_oe}, 32'h5);
   endtask
   // both open-drain and push-pull seen with either level on each pin
   task automatic pin_test();
      logic [7:0] v [4] = '{8'hFF, 8'h12, 8'h21, 8'h0C};
      logic [31:0] r;
      for (int i = 0; i < 4; i++)
      begin
         s0_lvl <= i[1];
         s1_lvl <= i[0];
         bus(A_STAT, 1'b1, v[i], r);
         rdck(A_STAT, {24'h0, v[i] & 8'h3F});
         repeat (2) @(posedge clk);
         #1;
         check({lim1, lim0}, {v[i][5], v[i][4]});
         check({p0_o, p0_oe}, v[i][0] ? {1'b0, ~i[1]} : {i[1], 1'b1});
         check({p1_o, p1_oe}, v[i][1] ? {1'b0, ~i[0]} : {i[0], 1'b1});
         @(posedge clk);
      end
   endtask
   // a write to an unused word must leave the control register alone
   task automatic unmapped_test();
      logic [31:0] r;
      bus(32'h40, 1'b1, 8'hFF, r);
      rdck(32'h40, 32'h0);
      bus(32'h0000_044C, 1'b1, 8'hFF, r);   // low bits match the control word, but the upper bits keep it unmapped
      rdck(A_STAT, 32'h0C);
   endtask
   task automatic mute_test();
      logic [31:0] r;
      for (int c = 0; c < 4; c++)
      begin
         chan_mute <= 4'hF;
         bus(A_MUTE, 1'b1, {4{c[1:0]}}, r);
         rdck(A_MUTE, {24'h0, {4{c[1:0]}}});
         repeat (2) @(posedge clk);
         #1;
         check({vcm, fhi, flo}, {c == 1 ? 4'hA : 4'h0, c == 2 ? 4'hA : 4'h0,
                                 c == 3 ? 4'hA : 4'h0});
         check({plo, nlo}, {c > 1 ? 4'h5 : 4'h0, c[0] ? 4'h5 : 4'h0});
         chan_mute <= 4'h0;
         repeat (2) @(posedge clk);
         #1;
         check({vcm, fhi, flo, plo, nlo}, 32'h0);
         @(posedge clk);
      end
      // distinct codes per channel pin down where each field sits
      chan_mute <= 4'hF;
      bus(A_MUTE, 1'b1, 8'hE4, r);
      repeat (2) @(posedge clk);
      #1;
      check({vcm, fhi, flo}, {4'h2, 4'h0, 4'h8});
      check({plo, nlo}, {4'h4, 4'h0});
      @(posedge clk);
   endtask
   // a low enable freezes the pins and stalls the bus although the level changes
   task automatic freeze_test();
      ce <= 1'b0;
      s0_lvl <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      check({p0_o, p0_oe, hreadyout, hresp}, 32'hC);
      @(posedge clk);
      ce <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check({p0_o, p0_oe, hreadyout, hresp}, 32'h6);
      @(posedge clk);
   endtask
   initial
   begin
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      reset_test();
      pin_test();
      unmapped_test();
      mute_test();
      freeze_test();
      conclude();
   end
   // the run needs about a hundred cycles, so this ceiling only catches a hang
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         err_count++;
         conclude();
      end
   end
endmodule // testbench
`default_nettype wire
